// [src/vih_params.svh]
`ifndef VIH_PARAMS_SVH
`define VIH_PARAMS_SVH
// source count and address width
`define VIH_NSRC      22
`define VIH_AW        8
// register byte addresses
`define VIH_A_SRCEN   8'h00
`define VIH_A_EXTEN1  8'h04
`define VIH_A_EXTEN2  8'h08
`define VIH_A_PRI0    8'h0c
`define VIH_A_PRI1    8'h10
`define VIH_A_PRI2    8'h14
`define VIH_A_TCTL    8'h18
`define VIH_A_PORT3_IRQ_FLAG_REG    8'h1c
`define VIH_A_PEND    8'h20
`define VIH_A_SER     8'h24
`define VIH_A_STAT    8'h28
// field positions
`define VIH_GEN_BIT   7
`define VIH_TC_IT0    0
`define VIH_TC_IE0    1
`define VIH_TC_IT1    2
`define VIH_TC_IE1    3
`define VIH_TC_TF0    5
`define VIH_TC_TF1    7
`define VIH_P3_POL6   2
`define VIH_P3_POL7   3
`define VIH_P3_IE6    5
`define VIH_P3_IE7    6
// source order indices
`define VIH_SRC_X0    0
`define VIH_SRC_T0    1
`define VIH_SRC_X1    2
`define VIH_SRC_T1    3
`define VIH_SRC_S0    4
`define VIH_SRC_X6    18
`define VIH_SRC_X7    19
`define VIH_SRC_S1    20
// vectors
`define VIH_VEC_RESET 16'h0000
`define VIH_VEC_BASE  16'h0003
`define VIH_VEC_SHIFT 3
`endif

// [src/vih_pkg.sv]
`include "vih_params.svh"
package vih_pkg;
    // whole handler state, registered in one place
    typedef struct packed {
        logic [7:0]           srcen;    // source_enable_reg
        logic [7:0]           exten1;   // ext_enable_reg_1
        logic [7:0]           exten2;   // ext_enable_reg_2
        logic [7:0]           pri0;     // priority_select_reg
        logic [7:0]           pri1;
        logic [7:0]           pri2;
        logic [7:0]           tctl;     // timer_control_reg, non-flag bits
        logic [7:0]           port3_irq_flag_reg;     // port3_irq_flag_reg, non-flag bits
        logic [`VIH_NSRC-1:0] pend;     // one pending flag per source
        logic [3:0]           ser;      // rx0, tx0, rx1, tx1
        logic [3:0]           sync1;    // pin synchroniser, first stage
        logic [3:0]           sync2;    // second stage
        logic [3:0]           prev;     // previous level for edge detect
        logic                 act_lo;   // low-level routine running
        logic                 act_hi;   // high-level routine running
        logic                 hold;     // one instruction after return
        logic                 req;      // request to core
        logic                 req_hi;   // winner is high level
        logic [4:0]           idx;      // winner order index
        logic [15:0]          vec;      // winner vector address
        logic [31:0]          rdata;
        logic                 ready;
        logic                 err;
    } vih_state_s;
endpackage

// [src/vih_handler.sv]
// Overview of operation
// - twenty-two sources, each low or high priority
// - events set pending flags even when disabled
// - enabled pending flag raises request, core calls vector
// - return resumes at the interrupted next instruction
// - disabled pending flags raise no request
// - global enable bit gates all source enables
// - per-source enable and priority bits, clear is low
// - only edge pins and timers cleared on vectoring (code clears timers and edge-mode pins zero/one; pins six/seven stay set)
// - flag left set re-enters after one instruction
// - software writing one acts as real event
// - pins zero/one active low, level or edge
// - pins zero/one flags in timer control bits
// - edge mode latches fall, cleared on vectoring
// - level mode flag mirrors the pin
// - pins six/seven edge detected, polarity selectable
// - reset vector zero; sources three plus eight each
// - high preempts low; level then fixed order
// - decode every clock; detect within one clock
// - equal or higher routine blocks until return plus one
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "vih_params.svh"
module vih_handler
    import vih_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`VIH_AW-1:0]   paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 ext_request_in_0_n, // active-low pin
    input  wire logic                 ext_request_in_1_n, // active-low pin
    input  wire logic                 ext_request_in_6,   // polarity from config
    input  wire logic                 ext_request_in_7,
    input  wire logic [`VIH_NSRC-1:0] periph_event,       // one-cycle set pulses
    input  wire logic [3:0]           serial_event,       // rx0, tx0, rx1, tx1
    input  wire logic                 core_irq_ack,       // core starts long_call
    input  wire logic                 core_return_from_interrupt_done,     // return completed
    input  wire logic                 core_instr_done,    // instruction completed
    output logic                      irq_req,
    output logic                      irq_req_high,
    output logic      [4:0]           irq_index,
    output logic      [15:0]          irq_vector
);

    vih_state_s r_q;                    // registered state
    vih_state_s r_d;                    // next state

    logic [`VIH_NSRC-1:0] en_all;       // effective enables
    logic [`VIH_NSRC-1:0] pri_all;      // per-source level
    logic [`VIH_NSRC-1:0] raw;          // pending incl. serial flags
    logic [`VIH_NSRC-1:0] hi_live;
    logic [`VIH_NSRC-1:0] lo_live;
    logic [3:0]           fall;         // falling edges of synced pins
    logic [3:0]           rise;         // rising edges of synced pins
    logic                 setup;        // apb setup cycle
    logic                 wr;           // write takes effect now
    logic                 allow_hi;
    logic                 allow_lo;
    logic [4:0]           win;
    logic                 win_hi;
    logic                 any;

    // all next-state logic in one process
    always_comb begin
        r_d      = r_q;
        setup    = psel & ~penable;
        wr       = psel & penable & r_q.ready & pwrite & ~r_q.err;

        // pins cross into pclk; edges look at stage two and later only
        r_d.sync1 = {ext_request_in_7, ext_request_in_6,
                     ext_request_in_1_n, ext_request_in_0_n};
        r_d.sync2 = r_q.sync1;
        r_d.prev  = r_q.sync2;
        fall      = r_q.prev & ~r_q.sync2;
        rise      = ~r_q.prev & r_q.sync2;

        // enables and priority spread over three byte registers
        en_all  = r_q.srcen[`VIH_GEN_BIT] ?
                  {r_q.exten2, r_q.exten1, r_q.srcen[5:0]} : '0;
        pri_all = {r_q.pri2, r_q.pri1, r_q.pri0[5:0]};

        // serial sources own two flags each
        raw = r_q.pend;
        raw[`VIH_SRC_S0] = r_q.pend[`VIH_SRC_S0] | (|r_q.ser[1:0]);
        raw[`VIH_SRC_S1] = r_q.pend[`VIH_SRC_S1] | (|r_q.ser[3:2]);

        // disabled flags simply drop out here
        hi_live = raw & en_all & pri_all;
        lo_live = raw & en_all & ~pri_all;

        // lowest order index wins inside a level, high level first
        win    = '0;
        win_hi = |hi_live;
        any    = (|hi_live) | (|lo_live);
        for (int i = `VIH_NSRC - 1; i >= 0; i--) begin
            if (win_hi ? hi_live[i] : lo_live[i]) begin
                win = 5'(i);
            end
        end

        // nesting: a running high routine blocks all, low blocks low
        allow_hi = ~r_q.act_hi & ~r_q.hold;
        allow_lo = ~r_q.act_hi & ~r_q.act_lo & ~r_q.hold;

        // apb: answer prepared in setup, shown in first access cycle
        r_d.ready = setup;
        r_d.err   = 1'b0;
        r_d.rdata = '0;
        if (setup && !pwrite) begin
            case (paddr)
                `VIH_A_SRCEN:  r_d.rdata[7:0] = r_q.srcen;
                `VIH_A_EXTEN1: r_d.rdata[7:0] = r_q.exten1;
                `VIH_A_EXTEN2: r_d.rdata[7:0] = r_q.exten2;
                `VIH_A_PRI0:   r_d.rdata[7:0] = r_q.pri0;
                `VIH_A_PRI1:   r_d.rdata[7:0] = r_q.pri1;
                `VIH_A_PRI2:   r_d.rdata[7:0] = r_q.pri2;
                `VIH_A_TCTL: begin
                    r_d.rdata[7:0]         = r_q.tctl;
                    r_d.rdata[`VIH_TC_IE0] = r_q.pend[`VIH_SRC_X0];
                    r_d.rdata[`VIH_TC_IE1] = r_q.pend[`VIH_SRC_X1];
                    r_d.rdata[`VIH_TC_TF0] = r_q.pend[`VIH_SRC_T0];
                    r_d.rdata[`VIH_TC_TF1] = r_q.pend[`VIH_SRC_T1];
                end
                `VIH_A_PORT3_IRQ_FLAG_REG: begin
                    r_d.rdata[7:0]         = r_q.port3_irq_flag_reg;
                    r_d.rdata[`VIH_P3_IE6] = r_q.pend[`VIH_SRC_X6];
                    r_d.rdata[`VIH_P3_IE7] = r_q.pend[`VIH_SRC_X7];
                end
                `VIH_A_PEND:   r_d.rdata[`VIH_NSRC-1:0] = raw;
                `VIH_A_SER:    r_d.rdata[3:0] = r_q.ser;
                `VIH_A_STAT:   r_d.rdata[9:0] = {r_q.act_hi, r_q.act_lo, r_q.hold,
                                                 r_q.req, r_q.req_hi, r_q.idx};
                default:       r_d.err = 1'b1;   // unmapped read
            endcase
        end else if (setup) begin
            case (paddr)
                `VIH_A_SRCEN, `VIH_A_EXTEN1, `VIH_A_EXTEN2, `VIH_A_PRI0,
                `VIH_A_PRI1, `VIH_A_PRI2, `VIH_A_TCTL, `VIH_A_PORT3_IRQ_FLAG_REG,
                `VIH_A_PEND, `VIH_A_SER: r_d.err = 1'b0;
                default:                 r_d.err = 1'b1; // status is read-only
            endcase
        end

        // software writes; a one on a flag acts like a real event
        if (wr) begin
            case (paddr)
                `VIH_A_SRCEN:  r_d.srcen  = pwdata[7:0];
                `VIH_A_EXTEN1: r_d.exten1 = pwdata[7:0];
                `VIH_A_EXTEN2: r_d.exten2 = pwdata[7:0];
                `VIH_A_PRI0:   r_d.pri0   = pwdata[7:0];
                `VIH_A_PRI1:   r_d.pri1   = pwdata[7:0];
                `VIH_A_PRI2:   r_d.pri2   = pwdata[7:0];
                `VIH_A_TCTL: begin
                    r_d.tctl = pwdata[7:0];
                    r_d.pend[`VIH_SRC_X0] = pwdata[`VIH_TC_IE0];
                    r_d.pend[`VIH_SRC_X1] = pwdata[`VIH_TC_IE1];
                    r_d.pend[`VIH_SRC_T0] = pwdata[`VIH_TC_TF0];
                    r_d.pend[`VIH_SRC_T1] = pwdata[`VIH_TC_TF1];
                end
                `VIH_A_PORT3_IRQ_FLAG_REG: begin
                    r_d.port3_irq_flag_reg = pwdata[7:0];
                    r_d.pend[`VIH_SRC_X6] = pwdata[`VIH_P3_IE6];
                    r_d.pend[`VIH_SRC_X7] = pwdata[`VIH_P3_IE7];
                end
                `VIH_A_PEND:   r_d.pend = pwdata[`VIH_NSRC-1:0];
                `VIH_A_SER:    r_d.ser  = pwdata[3:0];
                default:       r_d.pend = r_d.pend;
            endcase
        end

        // core takes the request: remember the level, clear hw flags
        if (core_irq_ack && r_q.req) begin
            r_d.req = 1'b0;
            if (r_q.req_hi) begin
                r_d.act_hi = 1'b1;
            end else begin
                r_d.act_lo = 1'b1;
            end
            if (r_q.idx == 5'(`VIH_SRC_T0) || r_q.idx == 5'(`VIH_SRC_T1)) begin
                r_d.pend[r_q.idx] = 1'b0;
            end
            if (r_q.idx == 5'(`VIH_SRC_X0) && r_q.tctl[`VIH_TC_IT0]) begin
                r_d.pend[`VIH_SRC_X0] = 1'b0;
            end
            if (r_q.idx == 5'(`VIH_SRC_X1) && r_q.tctl[`VIH_TC_IT1]) begin
                r_d.pend[`VIH_SRC_X1] = 1'b0;
            end
        end else begin
            // decoded every clock, one clock to detect
            r_d.req    = any & (win_hi ? allow_hi : allow_lo);
            r_d.req_hi = win_hi;
            r_d.idx    = win;
            r_d.vec    = `VIH_VEC_BASE +
                         {8'h00, win, 3'b000};
        end

        // return pops the innermost level, then one instruction must run
        if (core_return_from_interrupt_done) begin
            if (r_q.act_hi) begin
                r_d.act_hi = 1'b0;
            end else begin
                r_d.act_lo = 1'b0;
            end
            r_d.hold = 1'b1;
            r_d.req  = 1'b0;
        end else if (r_q.hold && core_instr_done) begin
            r_d.hold = 1'b0;
        end

        // events last so that a set beats a clear in the same cycle
        r_d.pend = r_d.pend | periph_event;
        r_d.ser  = r_d.ser | serial_event;
        if (r_q.tctl[`VIH_TC_IT0]) begin
            r_d.pend[`VIH_SRC_X0] = r_d.pend[`VIH_SRC_X0] | fall[0];
        end else begin
            r_d.pend[`VIH_SRC_X0] = ~r_q.sync2[0];
        end
        if (r_q.tctl[`VIH_TC_IT1]) begin
            r_d.pend[`VIH_SRC_X1] = r_d.pend[`VIH_SRC_X1] | fall[1];
        end else begin
            r_d.pend[`VIH_SRC_X1] = ~r_q.sync2[1];
        end
        // pins six and seven: polarity bit set means rising edge
        r_d.pend[`VIH_SRC_X6] = r_d.pend[`VIH_SRC_X6] |
            (r_q.port3_irq_flag_reg[`VIH_P3_POL6] ? rise[2] : fall[2]);
        r_d.pend[`VIH_SRC_X7] = r_d.pend[`VIH_SRC_X7] |
            (r_q.port3_irq_flag_reg[`VIH_P3_POL7] ? rise[3] : fall[3]);
    end

    // single state register; reset takes constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q       <= '0;
            r_q.sync1 <= 4'h3;              // active-low pins idle high
            r_q.sync2 <= 4'h3;
            r_q.prev  <= 4'h3;
            r_q.vec   <= `VIH_VEC_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from the state register
    assign prdata       = r_q.rdata;
    assign pready       = r_q.ready;
    assign pslverr      = r_q.err;
    assign irq_req      = r_q.req;
    assign irq_req_high = r_q.req_hi;
    assign irq_index    = r_q.idx;
    assign irq_vector   = r_q.vec;

endmodule
`default_nettype wire

// [test/vih_props.sv]
`timescale 1ns/100ps
`default_nettype none
module vih_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        core_irq_ack,
    input wire logic        core_return_from_interrupt_done,
    input wire logic        irq_req,
    input wire logic        irq_req_high,
    input wire logic [4:0]  irq_index,
    input wire logic [15:0] irq_vector
);
    logic hi_q, lo_q; // routine levels as the core sees them
    // track nesting from acks and returns; only two levels can stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else if (irq_req && core_irq_ack) begin
            hi_q <= hi_q | irq_req_high;
            lo_q <= lo_q | !irq_req_high;
        end else if (core_return_from_interrupt_done) begin
            hi_q <= 1'b0;
            lo_q <= lo_q & hi_q; // inner routine unwinds first
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_vec_from_idx: assert property (
        irq_req |-> irq_vector == 16'h0003 + {8'h00, irq_index, 3'h0}) else $error("bad vector");
    a_ack_drops_req: assert property (
        irq_req && core_irq_ack |=> !irq_req) else $error("request kept after ack");
    a_return_holds: assert property (
        core_return_from_interrupt_done |-> ##2 !irq_req) else $error("request inside return hold");
    a_high_unbroken: assert property (
        hi_q |-> !irq_req) else $error("high routine preempted");
    a_low_only_high: assert property (
        lo_q && irq_req |-> irq_req_high) else $error("low routine preempted by low");
    a_ready_first: assert property (
        $rose(penable) |-> pready) else $error("no ready in first access cycle");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready longer than one cycle");
    a_refuse_zero: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("refusal with data");
endmodule
bind vih_handler vih_props u_props (
    .pclk(pclk), .presetn(presetn), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_irq_ack(core_irq_ack), .core_return_from_interrupt_done(core_return_from_interrupt_done),
    .irq_req(irq_req), .irq_req_high(irq_req_high), .irq_index(irq_index),
    .irq_vector(irq_vector));
`default_nettype wire

// [test/vih_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module vih_core_model (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       irq_req,
    input wire logic [4:0] irq_index,
    input wire logic [7:0] run_len,
    output logic           core_irq_ack,
    output logic           core_return_from_interrupt_done,
    output logic           core_instr_done,
    output logic [4:0]     last_idx,
    output logic           idle,
    output int             takes
);
    int depth, cnt, post; // nesting, routine cycles left, instruction after return
    // behavioural core: short or long routines picked by run_len
    always @(posedge pclk or negedge presetn) begin
        core_irq_ack <= 1'b0;
        core_return_from_interrupt_done <= 1'b0;
        core_instr_done <= 1'b0;
        if (!presetn) begin
            {depth, cnt, post} = '0;
            takes <= 0;
            last_idx <= 5'h00;
        end else if (irq_req && !core_irq_ack && post == 0) begin
            core_irq_ack <= 1'b1;
            last_idx <= irq_index;
            takes <= takes + 1;
            depth = depth + 1;
            cnt = run_len;
        end else if (post > 0) begin
            post = post - 1;
            core_instr_done <= (post == 0);
        end else if (depth > 0) begin
            cnt = cnt - 1;
            if (cnt <= 0) begin
                core_return_from_interrupt_done <= 1'b1;
                depth = depth - 1;
                cnt = run_len;
                post = 3;
            end
        end
    end
    assign idle = depth == 0 && post == 0 && !irq_req;
endmodule
`default_nettype wire

// [test/tb_vectored_interrupt_handler.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_vectored_interrupt_handler;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, run_len = 8'h1e;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, ack, return_from_interrupt, idone, irq_req, irq_hi, idle;
    logic        x0_n = 1'b1, x1_n = 1'b1, x6 = 1'b0, x7 = 1'b1; // pins start inactive
    logic [21:0] pev = 22'h0, m, p;
    logic [3:0]  sev = 4'h0;
    logic [4:0]  irq_index, last_idx;
    logic [15:0] irq_vector;
    int          takes, failures = 0, total_checks = 0, seed = 99124, t0, i, k;
    vih_handler u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_request_in_0_n(x0_n), .ext_request_in_1_n(x1_n), .ext_request_in_6(x6),
        .ext_request_in_7(x7), .periph_event(pev), .serial_event(sev), .core_irq_ack(ack),
        .core_return_from_interrupt_done(return_from_interrupt), .core_instr_done(idone), .irq_req(irq_req),
        .irq_req_high(irq_hi), .irq_index(irq_index), .irq_vector(irq_vector));
    vih_core_model u_core (
        .pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_index(irq_index),
        .run_len(run_len), .core_irq_ack(ack), .core_return_from_interrupt_done(return_from_interrupt),
        .core_instr_done(idone), .last_idx(last_idx), .idle(idle), .takes(takes));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic test_done();
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; an idle cycle after it keeps psel from being driven twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) failures++;
        if (n >= 16) test_done();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // bounded wait for a new take, or for the core to fall idle
    task automatic wait_core(input bit idl);
        int n;
        for (n = 0; n < 400 && (idl ? idle !== 1'b1 : takes <= t0); n++) @(posedge pclk);
        if (n >= 400) failures++;
        if (n >= 400) test_done();
    endtask
    // compare winner and flags left standing, then clear them as software must
    task automatic serve(input logic [4:0] want, input logic [7:0] a, input logic [31:0] left);
        wait_core(1'b0);
        chk({27'h0, last_idx}, {27'h0, want});
        chk({16'h0, irq_vector}, 32'h3 + 32'(want) * 32'h8);
        rdc(a, left);
        apb(1'b1, a, 32'h0);
        wait_core(1'b1);
    endtask
    // higher level first, then lowest order index
    function automatic logic [4:0] exp_win(input logic [21:0] fl, input logic [21:0] pr);
        for (int j = 0; j < 22; j++) if (fl[j] && pr[j]) return j[4:0];
        for (int j = 0; j < 22; j++) if (fl[j]) return j[4:0];
        return 5'h00;
    endfunction
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 44; k += 4) rdc(k[7:0], 32'h0);
        apb(1'b1, 8'h28, 32'h1);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, e}, 32'h1);
        pev[6] <= 1'b1;
        @(posedge pclk);
        pev[6] <= 1'b0;
        rdc(8'h20, 32'h40);
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b1, 8'h08, 32'hff);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq_req}, 32'h0);
        t0 = takes;
        apb(1'b1, 8'h00, 32'hbf);
        serve(5'd6, 8'h20, 32'h40);
        t0 = takes;
        pev[8] <= 1'b1;
        @(posedge pclk);
        pev[8] <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, irq_req | ack}, 32'h1);
        serve(5'd8, 8'h20, 32'h100);
        // software sets; timer flags 1 and 3 are the only ones cleared on vectoring
        for (i = 0; i < 12; i++) begin
            k = i < 2 ? 2 * i + 1 : 4 + $unsigned($random(seed)) % 18;
            t0 = takes;
            apb(1'b1, 8'h20, 32'h1 << k);
            serve(k[4:0], 8'h20, (k == 1 || k == 3) ? 32'h0 : 32'h1 << k);
        end
        for (i = 0; i < 4; i++) begin
            t0 = takes;
            sev[i] <= 1'b1;
            @(posedge pclk);
            sev[i] <= 1'b0;
            serve(i < 2 ? 5'd4 : 5'd20, 8'h24, 32'h1 << i);
        end
        run_len <= 8'h04;
        t0 = takes;
        apb(1'b1, 8'h20, 32'h400);
        wait_core(1'b0);
        t0 = takes;
        serve(5'd10, 8'h20, 32'h400);
        for (i = 0; i < 8; i++) begin
            m = 22'($random(seed)) & 22'h3ffffa | 22'h200000;
            p = 22'($random(seed));
            apb(1'b1, 8'h0c, {26'h0, p[5:0]});
            apb(1'b1, 8'h10, {24'h0, p[13:6]});
            apb(1'b1, 8'h14, {24'h0, p[21:14]});
            t0 = takes;
            apb(1'b1, 8'h20, {10'h0, m});
            // only a timer winner loses its flag; the rest wait for software
            serve(exp_win(m, p), 8'h20,
                  {10'h0, m & ~(22'h00000a & (22'h1 << exp_win(m, p)))});
        end
        // a high request must break into a long low routine
        run_len <= 8'h10;
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h10, 32'h8);
        apb(1'b1, 8'h14, 32'h0);
        t0 = takes;
        apb(1'b1, 8'h20, 32'h1000);
        wait_core(1'b0);
        chk({27'h0, last_idx}, 32'hc);
        t0 = takes;
        apb(1'b1, 8'h20, 32'h1200);
        serve(5'd9, 8'h20, 32'h1200);
        apb(1'b1, 8'h18, 32'h1);
        t0 = takes;
        x0_n <= 1'b0;
        repeat (3) @(posedge pclk);
        x0_n <= 1'b1;
        serve(5'd0, 8'h18, 32'h1);
        apb(1'b1, 8'h00, 32'hbb);
        x1_n <= 1'b0;
        repeat (5) @(posedge pclk);
        rdc(8'h18, 32'h8);
        x1_n <= 1'b1;
        repeat (5) @(posedge pclk);
        rdc(8'h18, 32'h0);
        apb(1'b1, 8'h08, 32'hcf);
        apb(1'b1, 8'h1c, 32'h04);
        x6 <= 1'b1;
        x7 <= 1'b0;
        repeat (5) @(posedge pclk);
        rdc(8'h1c, 32'h64);
        test_done();
    end
endmodule
`default_nettype wire
